//--- core/bwm_cfg.svh
// Offsets, field positions, entry layout and timing counts of the bandwidth monitor access block
`ifndef BWM_CFG_SVH
`define BWM_CFG_SVH

`define BWM_OFS_SEL 16'h0800
`define BWM_OFS_LIVE 16'h0860
`define BWM_OFS_SNAP 16'h0868
`define BWM_OFS_WIDE_LO 16'h0880
`define BWM_OFS_WIDE_HI 16'h0884

`define BWM_SPACE_SEC 2'h0
`define BWM_SPACE_NSEC 2'h1
`define BWM_SPACE_ROOT 2'h2
`define BWM_SPACE_REALM 2'h3

`define BWM_NOT_READY_FLAG_BIT 31
`define BWM_SEL_MON_LSB 0
`define BWM_SEL_RIS_LSB 24
`define BWM_NARROW_CNT_W 44

`define BWM_ENT_W 96
`define BWM_ENT_LIVE_NOT_READY_FLAG 63
`define BWM_ENT_CAP_LSB 64
`define BWM_ENT_CAP_NOT_READY_FLAG 95

`define BWM_ACK_LAT 2

`endif

//--- core/bwm_pkg.sv
// Types shared by the bandwidth monitor access block
package bwm_pkg;

  typedef enum logic {BWM_ST_IDLE, BWM_ST_ACC} bwm_state_t;

  typedef enum logic [1:0] {BWM_OP_REG, BWM_OP_CAP, BWM_OP_INC} bwm_op_t;

endpackage : bwm_pkg

//--- core/bwm_mon_mem.sv
// Monitor entry memory with registered read data
`timescale 1ns/1ps
module bwm_mon_mem
  import bwm_pkg::*;
#(
  parameter int WIDTH = 96,
  parameter int AW = 8
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // Read port
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [1<<AW];
  logic [WIDTH-1:0] rd_data_r;

  always_ff @(posedge mclk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      rd_data_r <= '0;
    end
    else
    begin
      rd_data_r <= mem[rd_addr];
    end
  end

  assign rd_data = rd_data_r;

endmodule : bwm_mon_mem

//--- core/bwm_access.sv
// Bandwidth usage monitor register access for four security spaces
//
// Contract
// - Four separate monitor copies: secure, non-secure, root, realm, each on its own page.
// - Each space's copy reaches only its own monitors, no shared storage.
// - With resource select, live access targets resource index plus monitor index.
// - Without resource select, live access targets monitor index alone.
// - Live monitor register decoded at 0x0860, read-write.
// - Root and realm copies accessible only with the realm extension option.
// - Snapshot exists only with monitors, bandwidth monitors and capture; else reads zero.
// - Snapshot is 32 bits: not-ready in bit 31, count in 30:0.
// - Snapshot not-ready copies the live monitor's not-ready flag.
// - Snapshot count equals live scaled count at capture, scaling kept.
// - Snapshot exists as four per-space copies serving their own partitions.
// - Snapshot targets resource plus monitor index, or monitor index alone.
// - Snapshot register decoded at 0x0868, read-write.
// - Wide monitor exists only with monitors, bandwidth and long counters; else zero.
// - Wide monitor is 64 bits, four copies, chosen by own space's selection.
// - With resource select, wide access targets resource plus monitor index.
// - Live register: not-ready in bit 31, byte count in 30:0.
// - With scaling on, live count is bytes shifted right and rounded.
// - Wide option zero: not-ready bit 63, bits 62:44 zero, count 43:0.
// - Wide option one: 63-bit count in 62:0 under not-ready.
`timescale 1ns/1ps
`include "bwm_cfg.svh"
module bwm_access
  import bwm_pkg::*;
#(
  parameter int MON_W = 4,
  parameter int RIS_W = 2,
  parameter int BYTES_W = 16,
  parameter bit HAS_MONITORS = 1'b1,
  parameter bit HAS_BW_MON = 1'b1,
  parameter bit HAS_CAPTURE = 1'b1,
  parameter bit HAS_LONG = 1'b1,
  parameter bit RESOURCE_SELECT_SUPPORTED = 1'b1,
  parameter bit HAS_REALM_EXT = 1'b1,
  parameter bit WIDE_WIDTH_OPTION = 1'b0
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Register port, one feature page per security space
  input wire logic reg_req,
  input wire logic reg_we,
  input wire logic [1:0] reg_space,
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic reg_ready,
  output logic reg_ack,
  output logic [31:0] reg_rdata,
  // Capture events
  input wire logic cap_valid,
  input wire logic [1:0] cap_space,
  input wire logic [RIS_W-1:0] cap_ris,
  input wire logic [MON_W-1:0] cap_mon,
  output logic cap_ready,
  // Byte count events from the counting engine
  input wire logic inc_valid,
  input wire logic [1:0] inc_space,
  input wire logic [RIS_W-1:0] inc_ris,
  input wire logic [MON_W-1:0] inc_mon,
  input wire logic [BYTES_W-1:0] inc_bytes,
  output logic inc_ready,
  // Scaling control
  input wire logic scaling_on,
  input wire logic [5:0] scale_shift
);

  localparam int IDX_W = 2 + RIS_W + MON_W;
  localparam int DEPTH = 1 << IDX_W;
  localparam bit BW_PRESENT = HAS_MONITORS && HAS_BW_MON;
  localparam bit CAP_PRESENT = BW_PRESENT && HAS_CAPTURE;
  localparam bit LONG_PRESENT = BW_PRESENT && HAS_LONG;

  function automatic logic [IDX_W-1:0] bwm_idx(input logic [1:0] sp, input logic [RIS_W-1:0] resource_index,
                                               input logic [MON_W-1:0] mon);
    logic [RIS_W-1:0] r;
    r = RESOURCE_SELECT_SUPPORTED ? resource_index : '0;
    return {sp, r, mon};
  endfunction : bwm_idx

  function automatic logic bwm_space_ok(input logic [1:0] sp);
    return HAS_REALM_EXT || (sp == `BWM_SPACE_SEC) || (sp == `BWM_SPACE_NSEC);
  endfunction : bwm_space_ok

  function automatic logic [30:0] bwm_view32(input logic [62:0] cnt, input logic sc, input logic [5:0] sh);
    logic [63:0] t;
    t = {1'b0, cnt};
    if (sc && (sh != 6'h00))
    begin
      t = ({1'b0, cnt} + (64'h1 << (sh - 6'h01))) >> sh;
    end
    return t[30:0];
  endfunction : bwm_view32

  function automatic logic [62:0] bwm_wide_mask(input logic [62:0] cnt);
    logic [62:0] m;
    m = cnt;
    if (!WIDE_WIDTH_OPTION)
    begin
      m = {19'h0, cnt[`BWM_NARROW_CNT_W-1:0]};
    end
    return m;
  endfunction : bwm_wide_mask

  bwm_state_t state_r;
  bwm_op_t op_r, op_nxt;
  logic take, we_r, mem_we, sp_ok, live_not_ready_flag, reg_ack_r, acc_reg, any_hit;
  logic hit_sel, hit_live, hit_snap, hit_lo, hit_hi;
  logic [1:0] space_r;
  logic [15:0] addr_r;
  logic [31:0] wdata_r, rd_val, reg_rdata_r;
  logic [BYTES_W-1:0] bytes_r;
  logic [IDX_W-1:0] idx_r, idx_nxt;
  logic [MON_W-1:0] sel_mon_r [4];
  logic [RIS_W-1:0] sel_ris_r [4];
  logic [MON_W-1:0] sel_mon_cur;
  logic [RIS_W-1:0] sel_ris_cur;
  logic [DEPTH-1:0] valid_r;
  logic [`BWM_ENT_W-1:0] mem_rdata, ent, mem_wdata;
  logic [62:0] live_cnt, wide_cnt;
  logic [30:0] live_view;
  // Software first, then capture, then counting
  assign reg_ready = (state_r == BWM_ST_IDLE);
  assign cap_ready = reg_ready && !reg_req;
  assign inc_ready = reg_ready && !reg_req && !cap_valid;
  assign take = reg_ready && (reg_req || cap_valid || inc_valid);
  assign sel_mon_cur = sel_mon_r[reg_space];
  assign sel_ris_cur = sel_ris_r[reg_space];

  always_comb
  begin
    op_nxt = BWM_OP_INC;
    idx_nxt = bwm_idx(inc_space, inc_ris, inc_mon);
    if (reg_req)
    begin
      op_nxt = BWM_OP_REG;
      idx_nxt = bwm_idx(reg_space, sel_ris_cur, sel_mon_cur);
    end
    else if (cap_valid)
    begin
      op_nxt = BWM_OP_CAP;
      idx_nxt = bwm_idx(cap_space, cap_ris, cap_mon);
    end
  end
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      state_r <= BWM_ST_IDLE;
    end
    else
    begin
      state_r <= take ? BWM_ST_ACC : BWM_ST_IDLE;
    end
  end
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      op_r <= BWM_OP_INC;
      we_r <= 1'b0;
      space_r <= 2'h0;
      addr_r <= 16'h0000;
      wdata_r <= 32'h0000_0000;
      bytes_r <= '0;
      idx_r <= '0;
    end
    else if (take)
    begin
      op_r <= op_nxt;
      we_r <= reg_we;
      space_r <= reg_req ? reg_space : (cap_valid ? cap_space : inc_space);
      addr_r <= reg_addr;
      wdata_r <= reg_wdata;
      bytes_r <= inc_bytes;
      idx_r <= idx_nxt;
    end
  end
  // Space bits lead the index, so each space owns a disjoint slice of the memory
  bwm_mon_mem #(.WIDTH(`BWM_ENT_W), .AW(IDX_W)) u_mem (
    .mclk(mclk), .sys_rst(sys_rst), .wr_en(mem_we), .wr_addr(idx_r), .wr_data(mem_wdata),
    .rd_addr(idx_nxt), .rd_data(mem_rdata)
  );
  // Entries never written read as not ready with a zero count
  assign ent = valid_r[idx_r] ? mem_rdata : {1'b1, 31'h0, 1'b1, 63'h0};
  assign live_cnt = ent[`BWM_ENT_LIVE_NOT_READY_FLAG-1:0];
  assign live_not_ready_flag = ent[`BWM_ENT_LIVE_NOT_READY_FLAG];
  assign live_view = bwm_view32(live_cnt, scaling_on, scale_shift);
  assign wide_cnt = bwm_wide_mask(live_cnt);
  assign sp_ok = bwm_space_ok(space_r);
  assign hit_sel = sp_ok && BW_PRESENT && (addr_r == `BWM_OFS_SEL);
  assign hit_live = sp_ok && BW_PRESENT && (addr_r == `BWM_OFS_LIVE);
  assign hit_snap = sp_ok && CAP_PRESENT && (addr_r == `BWM_OFS_SNAP);
  assign hit_lo = sp_ok && LONG_PRESENT && (addr_r == `BWM_OFS_WIDE_LO);
  assign hit_hi = sp_ok && LONG_PRESENT && (addr_r == `BWM_OFS_WIDE_HI);

  always_comb
  begin
    mem_we = 1'b0;
    mem_wdata = ent;
    rd_val = 32'h0000_0000;
    if (state_r == BWM_ST_ACC)
    begin
      unique case (op_r)
        BWM_OP_INC:
        begin
          mem_we = sp_ok && BW_PRESENT;
          mem_wdata[`BWM_ENT_LIVE_NOT_READY_FLAG-1:0] = live_cnt + {{(63-BYTES_W){1'b0}}, bytes_r};
        end
        BWM_OP_CAP:
        begin
          mem_we = sp_ok && CAP_PRESENT;
          mem_wdata[`BWM_ENT_CAP_NOT_READY_FLAG] = live_not_ready_flag;
          mem_wdata[`BWM_ENT_CAP_NOT_READY_FLAG-1:`BWM_ENT_CAP_LSB] = live_view;
        end
        BWM_OP_REG:
        begin
          if (hit_sel)
          begin
            rd_val[`BWM_SEL_MON_LSB +: MON_W] = sel_mon_r[space_r];
            rd_val[`BWM_SEL_RIS_LSB +: RIS_W] = sel_ris_r[space_r];
          end
          else if (hit_live)
          begin
            rd_val = {live_not_ready_flag, live_view};
            mem_we = we_r;
            mem_wdata[`BWM_ENT_LIVE_NOT_READY_FLAG] = wdata_r[`BWM_NOT_READY_FLAG_BIT];
            mem_wdata[`BWM_ENT_LIVE_NOT_READY_FLAG-1:0] = {32'h0, wdata_r[30:0]};
          end
          else if (hit_snap)
          begin
            rd_val = ent[`BWM_ENT_CAP_NOT_READY_FLAG:`BWM_ENT_CAP_LSB];
            mem_we = we_r;
            mem_wdata[`BWM_ENT_CAP_NOT_READY_FLAG:`BWM_ENT_CAP_LSB] = wdata_r;
          end
          else if (hit_lo)
          begin
            rd_val = wide_cnt[31:0];
            mem_we = we_r;
            mem_wdata[`BWM_ENT_LIVE_NOT_READY_FLAG-1:0] = bwm_wide_mask({live_cnt[62:32], wdata_r});
          end
          else if (hit_hi)
          begin
            rd_val = {live_not_ready_flag, wide_cnt[62:32]};
            mem_we = we_r;
            mem_wdata[`BWM_ENT_LIVE_NOT_READY_FLAG] = wdata_r[`BWM_NOT_READY_FLAG_BIT];
            mem_wdata[`BWM_ENT_LIVE_NOT_READY_FLAG-1:0] = bwm_wide_mask({wdata_r[30:0], live_cnt[31:0]});
          end
        end
        default: mem_we = 1'b0;
      endcase
    end
  end
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      valid_r <= '0;
    end
    else if (mem_we)
    begin
      valid_r[idx_r] <= 1'b1;
    end
  end
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      sel_mon_r <= '{default: '0};
      sel_ris_r <= '{default: '0};
    end
    else if ((state_r == BWM_ST_ACC) && (op_r == BWM_OP_REG) && we_r && hit_sel)
    begin
      sel_mon_r[space_r] <= wdata_r[`BWM_SEL_MON_LSB +: MON_W];
      sel_ris_r[space_r] <= RESOURCE_SELECT_SUPPORTED ? wdata_r[`BWM_SEL_RIS_LSB +: RIS_W] : '0;
    end
  end
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      reg_ack_r <= 1'b0;
      reg_rdata_r <= 32'h0000_0000;
    end
    else
    begin
      reg_ack_r <= acc_reg;
      reg_rdata_r <= acc_reg ? (we_r ? 32'h0000_0000 : rd_val) : reg_rdata_r;
    end
  end
  assign reg_ack = reg_ack_r;
  assign reg_rdata = reg_rdata_r;
  assign acc_reg = (state_r == BWM_ST_ACC) && (op_r == BWM_OP_REG);
  assign any_hit = hit_sel || hit_live || hit_snap || hit_lo || hit_hi;

  AST_ACK_TIMING: assert property (@(posedge mclk) disable iff (sys_rst)
    (take && reg_req) |=> !reg_ack ##1 reg_ack)
    else $error("register answer not two cycles after request");
  AST_ABSENT_ZERO: assert property (@(posedge mclk) disable iff (sys_rst)
    (acc_reg && !any_hit) |=> (reg_rdata == 32'h0000_0000))
    else $error("absent register read not zero");
  AST_ABSENT_NOWRITE: assert property (@(posedge mclk) disable iff (sys_rst)
    (acc_reg && !any_hit) |-> !mem_we)
    else $error("absent register changed monitor state");
  AST_SPACE_SLICE: assert property (@(posedge mclk) disable iff (sys_rst)
    (state_r == BWM_ST_ACC) |-> (idx_r[IDX_W-1 -: 2] == space_r))
    else $error("entry index outside own space");
  AST_REALM_GATE: assert property (@(posedge mclk) disable iff (sys_rst)
    ((state_r == BWM_ST_ACC) && !HAS_REALM_EXT && space_r[1]) |-> !mem_we)
    else $error("root or realm copy written without extension");
  AST_SEL_MON: assert property (@(posedge mclk) disable iff (sys_rst)
    (take && reg_req) |=> (idx_r[MON_W-1:0] == $past(sel_mon_cur)))
    else $error("access did not follow monitor index");
  AST_NO_RIS: assert property (@(posedge mclk) disable iff (sys_rst)
    ((state_r == BWM_ST_ACC) && !RESOURCE_SELECT_SUPPORTED) |-> (idx_r[MON_W +: RIS_W] == '0))
    else $error("resource index used without resource select");
  AST_CAP_PAIR: assert property (@(posedge mclk) disable iff (sys_rst)
    ((state_r == BWM_ST_ACC) && (op_r == BWM_OP_CAP) && CAP_PRESENT && sp_ok)
    |-> (mem_we && (mem_wdata[`BWM_ENT_CAP_NOT_READY_FLAG] == ent[`BWM_ENT_LIVE_NOT_READY_FLAG])))
    else $error("capture did not copy flag with count");
  AST_WIDE_RES0: assert property (@(posedge mclk) disable iff (sys_rst)
    (acc_reg && hit_hi && !we_r && !WIDE_WIDTH_OPTION) |=> (reg_rdata[30:12] == 19'h0))
    else $error("wide monitor reserved bits not zero");

  COV_LIVE_READ: cover property (@(posedge mclk) disable iff (sys_rst) acc_reg && hit_live && !we_r);
  COV_CAPTURE: cover property (@(posedge mclk) disable iff (sys_rst)
    (state_r == BWM_ST_ACC) && (op_r == BWM_OP_CAP) && mem_we);
  COV_SNAP_READ: cover property (@(posedge mclk) disable iff (sys_rst) acc_reg && hit_snap && !we_r);
  COV_INC_STALL: cover property (@(posedge mclk) disable iff (sys_rst) inc_valid && !inc_ready);

endmodule : bwm_access

//--- verif/test_bandwidth_monitor_access.sv
// Self-checking testbench of the bandwidth monitor access block
`timescale 1ns/1ps
`include "bwm_cfg.svh"
module test_bandwidth_monitor_access;
  import bwm_pkg::*;
  localparam logic [31:0] NOT_READY_FLAG = 32'h8000_0000;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_req = 1'b0;
  logic reg_we = 1'b0;
  logic [1:0] reg_space = 2'h0;
  logic [15:0] reg_addr = 16'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic cap_valid = 1'b0;
  logic inc_valid = 1'b0;
  logic [1:0] ev_space = 2'h0;
  logic [1:0] ev_ris = 2'h0;
  logic [3:0] ev_mon = 4'h0;
  logic [15:0] inc_bytes = 16'h0;
  logic scaling_on = 1'b0;
  logic [5:0] scale_shift = 6'h0;
  logic reg_ready, reg_ack, cap_ready, min_ready, min_ack, min_cap_ready, inc_ready, min_inc_ready;
  logic [31:0] reg_rdata, min_rdata;
  int n_fail = 0;
  int tests_run = 0;

  always #5 mclk = ~mclk;

  bwm_access u_dut (
    .mclk(mclk), .sys_rst(sys_rst), .reg_req(reg_req), .reg_we(reg_we), .reg_space(reg_space),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_ready(reg_ready), .reg_ack(reg_ack),
    .reg_rdata(reg_rdata), .cap_valid(cap_valid), .cap_space(ev_space), .cap_ris(ev_ris),
    .cap_mon(ev_mon), .cap_ready(cap_ready), .inc_ready(inc_ready), .inc_valid(inc_valid), .inc_space(ev_space),
    .inc_ris(ev_ris), .inc_mon(ev_mon), .inc_bytes(inc_bytes), .scaling_on(scaling_on),
    .scale_shift(scale_shift)
  );

  // Reduced build: no capture, no wide monitor, no resource select, no root or realm pages
  bwm_access #(.HAS_CAPTURE(1'b0), .HAS_LONG(1'b0), .RESOURCE_SELECT_SUPPORTED(1'b0), .HAS_REALM_EXT(1'b0)) u_min (
    .mclk(mclk), .sys_rst(sys_rst), .reg_req(reg_req), .reg_we(reg_we), .reg_space(reg_space),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_ready(min_ready), .reg_ack(min_ack),
    .reg_rdata(min_rdata), .cap_valid(cap_valid), .cap_space(ev_space), .cap_ris(ev_ris),
    .cap_mon(ev_mon), .cap_ready(min_cap_ready), .inc_ready(min_inc_ready), .inc_valid(inc_valid),
    .inc_space(ev_space),
    .inc_ris(ev_ris), .inc_mon(ev_mon), .inc_bytes(inc_bytes), .scaling_on(scaling_on),
    .scale_shift(scale_shift)
  );

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
    begin
      $display("[ PASS ]");
    end
    else
    begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test

  task automatic hang(input string what);
    n_fail++;
    $display("ERROR at %0t: %s timed out", $time, what);
    end_of_test();
  endtask : hang

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk32

  task automatic reg_acc(input logic we, input logic [1:0] sp, input logic [15:0] a, input logic [31:0] d,
                         output logic [31:0] rd, output logic [31:0] rm);
    int n;
    @(posedge mclk);
    reg_req <= 1'b1;
    reg_we <= we;
    reg_space <= sp;
    reg_addr <= a;
    reg_wdata <= d;
    n = 0;
    @(negedge mclk);
    while (reg_ready !== 1'b1 || min_ready !== 1'b1)
    begin
      n++;
      if (n > 8) hang("request");
      @(negedge mclk);
    end
    @(posedge mclk);
    reg_req <= 1'b0;
    n = 1;
    @(negedge mclk);
    while (reg_ack !== 1'b1)
    begin
      if (n > 8) hang("answer");
      @(negedge mclk);
      n++;
    end
    chk32(32'(n), 32'h2, "answer latency");
    chk32({31'h0, min_ack}, 32'h1, "reduced build answer");
    rd = reg_rdata;
    rm = min_rdata;
  endtask : reg_acc

  task automatic wr(input logic [1:0] sp, input logic [15:0] a, input logic [31:0] d);
    logic [31:0] x, y;
    reg_acc(1'b1, sp, a, d, x, y);
    chk32(x | y, 32'h0, "write answer data");
  endtask : wr

  task automatic rc(input logic [1:0] sp, input logic [15:0] a, input logic [31:0] ed, input logic [31:0] em);
    logic [31:0] x, y;
    reg_acc(1'b0, sp, a, 32'h0, x, y);
    chk32(x, ed, "read data");
    chk32(y, em, "reduced build read data");
  endtask : rc

  // Capture (is_cap=1) or byte increment event, held until both builds are idle
  task automatic ev(input logic is_cap, input logic [1:0] sp, input logic [1:0] r, input logic [3:0] m,
                    input logic [15:0] b);
    int n;
    @(posedge mclk);
    cap_valid <= is_cap;
    inc_valid <= ~is_cap;
    ev_space <= sp;
    ev_ris <= r;
    ev_mon <= m;
    inc_bytes <= b;
    n = 0;
    @(negedge mclk);
    while ((is_cap ? cap_ready : inc_ready) !== 1'b1 || (is_cap ? min_cap_ready : min_inc_ready) !== 1'b1)
    begin
      n++;
      if (n > 8) hang("event");
      @(negedge mclk);
    end
    @(posedge mclk);
    cap_valid <= 1'b0;
    inc_valid <= 1'b0;
  endtask : ev

  task automatic done(input string name);
    $display("test %s finished, mismatches so far %0d", name, n_fail);
  endtask : done

  initial
  begin
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    rc(`BWM_SPACE_SEC, `BWM_OFS_LIVE, NOT_READY_FLAG, NOT_READY_FLAG);
    rc(`BWM_SPACE_SEC, `BWM_OFS_SNAP, NOT_READY_FLAG, 32'h0);
    rc(`BWM_SPACE_SEC, `BWM_OFS_WIDE_HI, NOT_READY_FLAG, 32'h0);
    done("reset");
    for (int s = 0; s < 4; s++)
    begin
      wr(s[1:0], `BWM_OFS_LIVE, 32'h100 + s);
    end
    for (int s = 0; s < 4; s++)
    begin
      rc(s[1:0], `BWM_OFS_LIVE, 32'h100 + s, (s < 2) ? 32'h100 + s : 32'h0);
      rc(s[1:0], `BWM_OFS_SNAP, NOT_READY_FLAG, 32'h0);
    end
    done("spaces");
    wr(`BWM_SPACE_NSEC, `BWM_OFS_SEL, 32'h0100_0003);
    wr(`BWM_SPACE_NSEC, `BWM_OFS_LIVE, 32'h0000_0118);
    rc(`BWM_SPACE_NSEC, `BWM_OFS_SEL, 32'h0100_0003, 32'h0000_0003);
    wr(`BWM_SPACE_NSEC, `BWM_OFS_SEL, 32'h0000_0003);
    rc(`BWM_SPACE_NSEC, `BWM_OFS_LIVE, NOT_READY_FLAG, 32'h118);
    wr(`BWM_SPACE_NSEC, `BWM_OFS_SEL, 32'h0100_0003);
    rc(`BWM_SPACE_NSEC, `BWM_OFS_LIVE, 32'h118, 32'h118);
    done("selection");
    ev(1'b0, `BWM_SPACE_NSEC, 2'h1, 4'h3, 16'h0010);
    rc(`BWM_SPACE_NSEC, `BWM_OFS_LIVE, 32'h128, 32'h128);
    @(posedge mclk);
    scaling_on <= 1'b1;
    scale_shift <= 6'h4;
    // (0x128 + 8) >> 4 with rounding
    rc(`BWM_SPACE_NSEC, `BWM_OFS_LIVE, 32'h13, 32'h13);
    ev(1'b1, `BWM_SPACE_NSEC, 2'h1, 4'h3, 16'h0);
    @(posedge mclk);
    scaling_on <= 1'b0;
    rc(`BWM_SPACE_NSEC, `BWM_OFS_LIVE, 32'h128, 32'h128);
    rc(`BWM_SPACE_NSEC, `BWM_OFS_SNAP, 32'h13, 32'h0);
    wr(`BWM_SPACE_NSEC, `BWM_OFS_LIVE, 32'h8000_0005);
    ev(1'b1, `BWM_SPACE_NSEC, 2'h1, 4'h3, 16'h0);
    rc(`BWM_SPACE_NSEC, `BWM_OFS_SNAP, 32'h8000_0005, 32'h0);
    rc(`BWM_SPACE_SEC, `BWM_OFS_SNAP, NOT_READY_FLAG, 32'h0);
    done("capture");
    wr(`BWM_SPACE_SEC, `BWM_OFS_SNAP, 32'h1234_5678);
    rc(`BWM_SPACE_SEC, `BWM_OFS_SNAP, 32'h1234_5678, 32'h0);
    wr(`BWM_SPACE_SEC, `BWM_OFS_WIDE_LO, 32'hdead_beef);
    wr(`BWM_SPACE_SEC, `BWM_OFS_WIDE_HI, 32'hffff_ffff);
    rc(`BWM_SPACE_SEC, `BWM_OFS_WIDE_LO, 32'hdead_beef, 32'h0);
    rc(`BWM_SPACE_SEC, `BWM_OFS_WIDE_HI, 32'h8000_0fff, 32'h0);
    done("wide");
    wr(`BWM_SPACE_NSEC, 16'h0870, 32'hffff_ffff);
    rc(`BWM_SPACE_NSEC, 16'h0870, 32'h0, 32'h0);
    rc(`BWM_SPACE_NSEC, `BWM_OFS_LIVE, 32'h8000_0005, 32'h8000_0005);
    wr(`BWM_SPACE_REALM, `BWM_OFS_SNAP, 32'h0000_0042);
    rc(`BWM_SPACE_REALM, `BWM_OFS_SNAP, 32'h0000_0042, 32'h0);
    done("reserved");
    end_of_test();
  end
endmodule : test_bandwidth_monitor_access
